// ===== i2c_slave_pkg.sv
// Shared constants and types for the two-wire register access slave.
// Contract
// - Serial clock is input only, never driven.
// - Data line only pulled low or released.
// - START, address+direction, pointer, data, STOP.
// - START/STOP are data edges while clock high.
// - Idle bus: both lines high, nobody pulls.
// - Data changes only while clock is low.
// - Ninth clock carries acknowledge, held low.
// - Device acknowledges every byte written.
// - Eighth bit: low write, high read.
// - Answer slave address 1001100, option range.
// - Watch for START plus own address.
// - Address byte 0x98 write, 0x99 read.
// - Pointer-only write modifies no register.
// - STOP clears register pointer to 0x00.
// - Repeated START keeps the register pointer.
// - Write data stored from pointer, incrementing.
// - Read data from pointer, then increment.
package i2c_slave_pkg;

  localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h4C;
  localparam logic [7:0] PTR_RESET          = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE      = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT      = 4'h7;
  localparam logic [3:0] CNT_RESET          = 4'h0;
  localparam logic [1:0] PIN_SYNC_RESET     = 2'h3;
  localparam logic [0:0] TOG_SYNC_RESET     = 1'h0;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_ADDR  = 3'h1,
    S_PTR   = 3'h3,
    S_WRITE = 3'h2,
    S_READ  = 3'h6
  } slave_state_t;

endpackage

// ===== bit_sync.sv
// Two-flop level synchroniser with a constant reset value.
`timescale 1ns/10ps
module bit_sync import i2c_slave_pkg::*; #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // The first stage feeds only the second stage.
  always_comb begin
    next_s        = s;
    next_s.meta   = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{meta: RST_VAL, stable: RST_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign q = s.stable;

endmodule

// ===== link_bit_capture.sv
// Serial-clock domain: samples the data line on each rising serial clock edge.
`timescale 1ns/10ps
module link_bit_capture import i2c_slave_pkg::*; (
  input  wire logic scl,
  input  wire logic arst_n,
  input  wire logic sda_in,
  output logic      bit_val,
  output logic      bit_tog
);

  typedef struct packed {
    logic tog;
    logic val;
  } cap_state_t;

  cap_state_t s;
  cap_state_t next_s;

  // The captured bit stays put until the next rising edge, which is far longer
  // than the toggle needs to cross, so the other domain may read it directly.
  always_comb begin
    next_s     = s;
    next_s.tog = ~s.tog;
    next_s.val = sda_in;
  end

  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{tog: 1'b0, val: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign bit_val = s.val;
  assign bit_tog = s.tog;

endmodule

// ===== i2c_reg_slave.sv
// Two-wire slave that reads and writes the device register file.
`timescale 1ns/10ps
module i2c_reg_slave import i2c_slave_pkg::*; #(
  parameter logic [6:0] SLAVE_ADDR = DEFAULT_SLAVE_ADDR
) (
  input  wire logic       CLK,
  input  wire logic       ARST_N,
  input  wire logic       SCL,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE,
  output logic            BUSY,
  output logic [7:0]      REG_ADDR,
  output logic [7:0]      REG_WDATA,
  output logic            REG_WE,
  input  wire logic [7:0] REG_RDATA
);

  typedef struct packed {
    slave_state_t state;
    logic [3:0]   cnt;
    logic [7:0]   rx;
    logic [7:0]   tx;
    logic [7:0]   ptr;
    logic [7:0]   wdata;
    logic         we;
    logic         ack_ok;
    logic         rw;
    logic         sda_oe;
    logic         sda_o;
    logic         busy;
    logic         prev_scl;
    logic         prev_sda;
    logic         prev_tog;
  } slave_regs_t;

  slave_regs_t s;
  slave_regs_t next_s;

  logic [1:0] pins_sync;
  logic       scl_s;
  logic       sda_s;
  logic       link_val;
  logic       link_tog;
  logic       tog_s;
  logic       start_det;
  logic       stop_det;
  logic       scl_fall;
  logic       bit_ev;

  function automatic logic addr_match(input logic [6:0] rx_addr);
    addr_match = (rx_addr == SLAVE_ADDR);
  endfunction

  // The serial clock is only ever observed, never driven.
  bit_sync #(
    .W       (2),
    .RST_VAL (PIN_SYNC_RESET)
  ) u_pin_sync (
    .clk    (CLK),
    .arst_n (ARST_N),
    .d      ({SCL, SDA_I}),
    .q      (pins_sync)
  );

  link_bit_capture u_capture (
    .scl     (SCL),
    .arst_n  (ARST_N),
    .sda_in  (SDA_I),
    .bit_val (link_val),
    .bit_tog (link_tog)
  );

  bit_sync #(
    .W       (1),
    .RST_VAL (TOG_SYNC_RESET)
  ) u_tog_sync (
    .clk    (CLK),
    .arst_n (ARST_N),
    .d      (link_tog),
    .q      (tog_s)
  );

  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  // Data edges while the clock stays high mark frame boundaries.
  assign start_det = scl_s && s.prev_scl && s.prev_sda && !sda_s;
  assign stop_det  = scl_s && s.prev_scl && !s.prev_sda && sda_s;
  assign scl_fall  = s.prev_scl && !scl_s;
  // A toggle change means a new bit was captured on the serial clock.
  assign bit_ev    = tog_s ^ s.prev_tog;

  always_comb begin
    next_s          = s;
    next_s.we       = 1'b0;
    next_s.sda_o    = 1'b0;
    next_s.prev_scl = scl_s;
    next_s.prev_sda = sda_s;
    next_s.prev_tog = tog_s;
    if (stop_det) begin
      next_s.state  = S_IDLE;
      next_s.ptr    = PTR_RESET;
      next_s.cnt    = CNT_RESET;
      next_s.sda_oe = 1'b0;
      next_s.ack_ok = 1'b0;
    end else if (start_det) begin
      // A repeated start leaves the pointer alone so a read can follow.
      next_s.state  = S_ADDR;
      next_s.cnt    = CNT_RESET;
      next_s.sda_oe = 1'b0;
      next_s.ack_ok = 1'b0;
    end else begin
      if (bit_ev && (s.state != S_IDLE)) begin
        if (s.cnt != BITS_PER_BYTE) begin
          next_s.rx  = {s.rx[6:0], link_val};
          next_s.cnt = s.cnt + 4'h1;
          if (s.state == S_READ) begin
            next_s.tx = {s.tx[6:0], 1'b0};
          end
          if (s.cnt == LAST_DATA_BIT) begin
            case (s.state)
              S_ADDR: begin
                next_s.ack_ok = addr_match(s.rx[6:0]);
                next_s.rw     = link_val;
              end
              S_PTR: begin
                next_s.ack_ok = 1'b1;
              end
              S_WRITE: begin
                next_s.ack_ok = 1'b1;
                next_s.wdata  = {s.rx[6:0], link_val};
                next_s.we     = 1'b1;
              end
              S_READ: begin
                // Advancing now gives the register file a full bit time
                // to present the next byte before it is loaded.
                next_s.ptr    = s.ptr + 8'h01;
                next_s.ack_ok = 1'b0;
              end
              default: begin
                next_s.ack_ok = 1'b0;
              end
            endcase
          end
        end else begin
          // This event is the ninth, acknowledge, bit.
          next_s.cnt = CNT_RESET;
          case (s.state)
            S_ADDR: begin
              if (!s.ack_ok) begin
                next_s.state = S_IDLE;
              end else if (s.rw) begin
                next_s.state = S_READ;
                next_s.tx    = REG_RDATA;
              end else begin
                next_s.state = S_PTR;
              end
            end
            S_PTR: begin
              next_s.ptr   = s.rx;
              next_s.state = S_WRITE;
            end
            S_WRITE: begin
              next_s.ptr = s.ptr + 8'h01;
            end
            S_READ: begin
              if (link_val) begin
                next_s.state = S_IDLE;
              end else begin
                next_s.tx = REG_RDATA;
              end
            end
            default: begin
              next_s.state = S_IDLE;
            end
          endcase
        end
      end
      // The data line only moves while the clock is low.
      if (scl_fall) begin
        case (s.state)
          S_IDLE: begin
            next_s.sda_oe = 1'b0;
          end
          S_READ: begin
            next_s.sda_oe = (s.cnt != BITS_PER_BYTE) && !s.tx[7];
          end
          default: begin
            next_s.sda_oe = (s.cnt == BITS_PER_BYTE) && s.ack_ok;
          end
        endcase
      end
    end
    next_s.busy = (next_s.state != S_IDLE);
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s <= '{
        state:    S_IDLE,
        cnt:      CNT_RESET,
        rx:       8'h00,
        tx:       8'h00,
        ptr:      PTR_RESET,
        wdata:    8'h00,
        we:       1'b0,
        ack_ok:   1'b0,
        rw:       1'b0,
        sda_oe:   1'b0,
        sda_o:    1'b0,
        busy:     1'b0,
        prev_scl: 1'b1,
        prev_sda: 1'b1,
        prev_tog: 1'b0
      };
    end else begin
      s <= next_s;
    end
  end

  assign SDA_O     = s.sda_o;
  assign SDA_OE    = s.sda_oe;
  assign BUSY      = s.busy;
  assign REG_ADDR  = s.ptr;
  assign REG_WDATA = s.wdata;
  assign REG_WE    = s.we;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  sequence seq_addr_last_bit;
    (s.state == S_ADDR) && bit_ev && !start_det && !stop_det && (s.cnt == LAST_DATA_BIT);
  endsequence

  sequence seq_read_byte_done;
    (s.state == S_READ) && bit_ev && !start_det && !stop_det && (s.cnt == LAST_DATA_BIT);
  endsequence

  sequence seq_write_byte_done;
    (s.state == S_WRITE) && bit_ev && !start_det && !stop_det && (s.cnt == LAST_DATA_BIT);
  endsequence

  chk_sda_low_only: assert property (SDA_O == 1'b0)
    else $error("Data line output value is not low.");

  chk_oe_rise_scl_low: assert property ($rose(SDA_OE) |-> !$past(scl_s))
    else $error("Data line pulled while clock was high.");

  chk_stop_clears_ptr: assert property (stop_det |=> (REG_ADDR == PTR_RESET) && !BUSY)
    else $error("Stop did not clear the pointer and return to idle.");

  chk_rstart_keeps_ptr: assert property (start_det |=>
      $stable(REG_ADDR) && (s.state == S_ADDR))
    else $error("Start changed the pointer or missed the address phase.");

  chk_idle_released: assert property ((s.state == S_IDLE) && !$past(SDA_OE) |-> !SDA_OE)
    else $error("Data line pulled while the slave is idle.");

  chk_addr_match_ack: assert property (seq_addr_last_bit |=>
      (s.ack_ok == (s.rx[7:1] == SLAVE_ADDR)) && (s.rw == s.rx[0]))
    else $error("Address compare or direction capture is wrong.");

  chk_write_strobe: assert property (seq_write_byte_done |=>
      REG_WE && (REG_WDATA == s.rx) ##1 !REG_WE)
    else $error("Write strobe not a single pulse with the received byte.");

  chk_write_only_data: assert property (REG_WE |-> $past(s.state) == S_WRITE)
    else $error("Register written outside the data phase.");

  chk_read_ptr_step: assert property (seq_read_byte_done |=>
      REG_ADDR == $past(REG_ADDR) + 8'h01)
    else $error("Pointer did not advance after a read byte.");

  // The acknowledge must stay low through the whole high phase of the ninth clock, so it
  // outlives the counter wrap until the clock is seen falling.
  chk_ack_slot_only: assert property (SDA_OE && (s.state != S_READ) |->
      (s.cnt == BITS_PER_BYTE) || ((s.cnt == CNT_RESET) && s.prev_scl))
    else $error("Acknowledge driven outside the ninth bit.");

  chk_addr_to_ptr: assert property ((s.state == S_ADDR) && bit_ev && !start_det && !stop_det
      && (s.cnt == BITS_PER_BYTE) && s.ack_ok && !s.rw |=> s.state == S_PTR)
    else $error("Write address did not lead to the pointer byte.");

endmodule

// ===== i2c_bus_master.sv
// Behavioural two-wire bus master that clocks every transfer.
`timescale 1ns/10ps
module i2c_bus_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Both lines are released, so the pull-up holds the idle bus high.
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Data moves only mid low phase, so it is stable while the clock is high.
  task automatic clk_bit(input logic b, output logic s);
    #40 sda_low = ~b;
    #40 scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
  endtask

  // Long lead-in lets the slave drop its acknowledge before a repeated start.
  task automatic start();
    #80 sda_low = 1'b0;
    #80 scl = 1'b1;
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
  endtask

  task automatic stop();
    #40 sda_low = 1'b1;
    #40 scl = 1'b1;
    #80 sda_low = 1'b0;
    #80;
  endtask

  // The ninth pulse is ours; the slave answers on it.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(~ack, s);
  endtask
endmodule

// ===== i2c_register_access_slave_test.sv
// Self-checking bench for the two-wire register access slave.
`timescale 1ns/10ps
module i2c_register_access_slave_test import i2c_slave_pkg::*;;
  logic            clk;
  logic            arst_n;
  logic            scl;
  logic            sda_low;
  logic            sda_o;
  logic            sda_oe;
  logic            busy;
  logic [7:0]      reg_addr;
  logic [7:0]      reg_wdata;
  logic            reg_we;
  logic [7:0]      regs [256];
  int              wr_cnt;
  int              error_cnt;
  int              checks_done;
  wire logic       sda = ~(sda_low | sda_oe);
  wire logic [7:0] reg_rdata = regs[reg_addr];

  i2c_reg_slave #(
    .SLAVE_ADDR(DEFAULT_SLAVE_ADDR)
  ) dut (
    .CLK      (clk),
    .ARST_N   (arst_n),
    .SCL      (scl),
    .SDA_I    (sda),
    .SDA_O    (sda_o),
    .SDA_OE   (sda_oe),
    .BUSY     (busy),
    .REG_ADDR (reg_addr),
    .REG_WDATA(reg_wdata),
    .REG_WE   (reg_we),
    .REG_RDATA(reg_rdata)
  );

  i2c_bus_master bus (
    .scl    (scl),
    .sda_low(sda_low),
    .sda    (sda)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (reg_we === 1'b1) begin
      regs[reg_addr] <= reg_wdata;
      wr_cnt <= wr_cnt + 1;
    end
    if (sda_oe === 1'b1) begin
      check(sda_o, 8'h00, "pin driven high");
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Offsets the link by 7 ns so its edges never meet the system clock edges.
  task automatic settle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) begin
      error_cnt++;
      $display("[ERR] %0t device stays busy", $time);
      stop_test();
    end
    @(negedge clk);
    #7;
  endtask

  task automatic t_write_burst();
    logic       a;
    logic [7:0] d [3] = '{8'hA1, 8'hB2, 8'hC3};
    bus.start();
    bus.wr_byte(8'h98, a);
    check(a, 8'h01, "write address ack");
    bus.wr_byte(8'hFE, a);
    check(a, 8'h01, "pointer ack");
    for (int i = 0; i < 3; i++) begin
      bus.wr_byte(d[i], a);
      check(a, 8'h01, "data ack");
    end
    bus.stop();
    settle();
    check(reg_addr, PTR_RESET, "pointer after stop");
    check(sda, 8'h01, "bus idle high");
    for (int i = 0; i < 3; i++) begin
      check(regs[8'(8'hFE + i)], d[i], "stored byte");
    end
  endtask

  task automatic t_wrong_addr();
    logic a;
    int   w0;
    w0 = wr_cnt;
    bus.start();
    bus.wr_byte(8'h9A, a);
    check(a, 8'h00, "foreign address ack");
    bus.wr_byte(8'h20, a);
    bus.wr_byte(8'h55, a);
    check(a, 8'h00, "ack when not addressed");
    bus.stop();
    settle();
    check(8'(wr_cnt - w0), 8'h00, "foreign write count");
  endtask

  task automatic t_ptr_only();
    logic a;
    int   w0;
    w0 = wr_cnt;
    bus.start();
    bus.wr_byte(8'h98, a);
    check(a, 8'h01, "address ack after refusal");
    bus.wr_byte(8'h10, a);
    check(reg_addr, 8'h10, "pointer loaded");
    bus.stop();
    settle();
    check(8'(wr_cnt - w0), 8'h00, "pointer-only write count");
    check(reg_addr, PTR_RESET, "pointer after stop");
  endtask

  task automatic t_read();
    logic       a;
    logic [7:0] q;
    logic [7:0] e [3] = '{8'hA1, 8'hB2, 8'hC3};
    bus.start();
    bus.wr_byte(8'h98, a);
    bus.wr_byte(8'hFE, a);
    bus.start();
    bus.wr_byte(8'h99, a);
    check(a, 8'h01, "read address ack");
    for (int i = 0; i < 3; i++) begin
      bus.rd_byte(i < 2, q);
      check(q, e[i], "read byte");
    end
    check(sda_oe, 8'h00, "released after nak");
    bus.stop();
    settle();
    check(reg_addr, PTR_RESET, "pointer after read");
  endtask

  initial begin
    arst_n      = 1'b0;
    wr_cnt      = 0;
    error_cnt   = 0;
    checks_done = 0;
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'(i) ^ 8'h5A;
    end
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    #7;
    check(busy, 8'h00, "idle after reset");
    t_write_burst();
    t_wrong_addr();
    t_ptr_only();
    t_read();
    stop_test();
  end

  initial begin
    #200000;
    error_cnt++;
    $display("[ERR] %0t run did not finish", $time);
    stop_test();
  end
endmodule
